// ---- timer_irq_pkg.sv ----
// constants shared by the timer / interrupt gathering block
`default_nettype none
package timer_irq_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] OFS_TIMER_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_TIMER_LOW      = 8'h04;
	localparam logic [7:0] OFS_TIMER_HIGH     = 8'h08;
	localparam logic [7:0] OFS_PIN_SELECT     = 8'h0c;
	localparam logic [7:0] OFS_MAIN_REQUEST   = 8'h10;
	localparam logic [7:0] OFS_IRQ_CONTROL    = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASKS      = 8'h18;
	localparam logic [7:0] OFS_PORT_CONFIG    = 8'h1c;
	localparam logic [7:0] OFS_BUZZER_CONTROL = 8'h20;
	// field positions
	localparam int AUTO_BIT       = 3;
	localparam int RUN_BIT        = 3;
	localparam int PIN_SRC_BIT    = 0;
	localparam int GLOBAL_IRQ_ENABLE_BIT      = 0;
	localparam int DEBOUNCER_CLOCK_SELECT_BIT      = 1;
	localparam int REQ_PORTA_BIT  = 0;
	localparam int REQ_PORTC_BIT  = 1;
	localparam int REQ_TIMER_BIT  = 2;
	localparam int REQ_PRESC_BIT  = 3;
	localparam int SLEEP_BIT      = 2;
	localparam int TIMER_MASK_BIT_BIT       = 0;
	localparam int GUARD_BIT      = 3;
	localparam int EDGE_BIT       = 0;
	localparam int BYPASS_BIT     = 1;
	localparam logic [3:0] RESET_NIBBLE = 4'h0;
	// count sources
	localparam logic [2:0] SRC_OFF = 3'h0;
	localparam logic [2:0] SRC_PIN = 3'h7;
	// prescaler: 32768 hz base, tap = base >> shift
	localparam int unsigned CLK_HZ        = 100000000;
	localparam int unsigned BASE_HZ       = 32768;
	localparam int unsigned BASE_TICK_CYC = CLK_HZ / BASE_HZ;
	localparam int PRESC_W = 15;
	localparam int SH_2048 = 4;
	localparam int SH_512  = 6;
	localparam int SH_128  = 8;
	localparam int SH_32   = 10;
	localparam int SH_8    = 12;
	localparam int SH_1    = 15;
	// debouncer sample periods
	localparam int unsigned DEB_SHORT_MS  = 2;
	localparam int unsigned DEB_LONG_MS   = 16;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
	localparam int unsigned DEB_SHORT_CYC = DEB_SHORT_MS * CYC_PER_MS;
	localparam int unsigned DEB_LONG_CYC  = DEB_LONG_MS * CYC_PER_MS;
	localparam int DEB_W = 21;
endpackage : timer_irq_pkg
`default_nettype wire

// ---- pin_edge_if.sv ----
// carrier between the timer core and the counter pin edge unit
`timescale 1ns/1ns
`default_nettype none
interface pin_edge_if;
	logic pin_level;
	logic sample_tick;
	logic bypass;
	logic pick_fall;
	logic edge_pulse;
	modport ctrl (output pin_level, output sample_tick, output bypass, output pick_fall, input edge_pulse);
	modport unit (input pin_level, input sample_tick, input bypass, input pick_fall, output edge_pulse);
endinterface : pin_edge_if
`default_nettype wire

// ---- pin_edge_unit.sv ----
// debouncer and edge picker for the counter input pin
`timescale 1ns/1ns
`default_nettype none
module pin_edge_unit (
	input wire logic  pclk,
	input wire logic  presetn,
	pin_edge_if.unit  pe
);
	logic prev_sample_r;
	logic deb_r;
	logic last_r;
	logic sel_level;
	logic edge_r;

	// level is accepted once two samples in a row agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_sample_r <= 1'b0;
			deb_r         <= 1'b0;
		end else if (pe.sample_tick) begin
			prev_sample_r <= pe.pin_level;
			if (prev_sample_r == pe.pin_level) begin
				deb_r <= pe.pin_level;
			end
		end
	end

	assign sel_level = pe.bypass ? pe.pin_level : deb_r; // R12

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_r <= 1'b0;
			edge_r <= 1'b0;
		end else begin
			last_r <= sel_level;
			edge_r <= pe.pick_fall ? (last_r & ~sel_level) : (~last_r & sel_level); // R12
		end
	end

	assign pe.edge_pulse = edge_r;
endmodule : pin_edge_unit
`default_nettype wire

// ---- countdown_timer_irq.sv ----
// 8-bit countdown timer / event counter with interrupt request gathering
// How it works
// R1 - eight-bit down counter clocked by a prescaler tap or counter pin edges
// R2 - reaching zero sets the timer flag; cpu request needs its mask too
// R3 - auto-reload select resets to zero, meaning no reload
// R4 - counter run bit in buzzer control starts/stops counting, reset off
// R5 - counting starts from the loaded value when the low nibble is written
// R6 - high nibble waits pending and commits only with a low-nibble write
// R7 - auto-reload takes effect only at the next low-nibble write
// R8 - auto mode: at zero raise event, reload value, keep counting
// R9 - loading zero stops the counter and clears auto-reload select
// R10 - reads return current count; low read freezes high nibble for next read
// R11 - source 0 off, 1..6 taps 2048 to 1 hz, 7 the pin
// R12 - pin select picks debounced rising, or bypass/edge chosen by port bits
// R13 - cpu interrupt needs flag, its mask (port flags have none) and the global enable
// R14 - all mask bits reset to zero
// R15 - halt sets global enable unless it starts an automatic serial transfer
// R16 - timer and prescaler flags clear when the main request register is read
// R17 - port flags clear only on reads of their own port request registers
// R18 - reset and sleep entry clear the global enable
// R19 - requests during service are kept and interrupt again after it
// R20 - writing one to bit 2 of main request enters sleep if guard set
// R21 - timer and prescaler flags set regardless of masks
// R22 - debouncer clock select: 0 gives 2 ms, 1 gives 16 ms
// R23 - disabled or source off: counter holds its value
`timescale 1ns/1ns
`default_nettype none
module countdown_timer_irq #(
	parameter int unsigned DEB_SHORT_CYC = timer_irq_pkg::DEB_SHORT_CYC,
	parameter int unsigned DEB_LONG_CYC  = timer_irq_pkg::DEB_LONG_CYC,
	parameter int unsigned TICK_CYC      = timer_irq_pkg::BASE_TICK_CYC,
	parameter int          AW            = 8
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          counter_input_pin,
	input  wire logic          porta_irq_in,
	input  wire logic          portc_irq_in,
	input  wire logic          porta_req_read,
	input  wire logic          portc_req_read,
	input  wire logic          halt_exec,
	input  wire logic          swb_auto_start,
	input  wire logic          irq_in_service,
	input  wire logic          wake_event,
	output logic               cpu_irq,
	output logic               sleep_mode
);
	////////////////////////////////////////////////////////////////////////////
	// register state
	logic [3:0]  timer_control_r;
	logic [3:0]  pin_select_r;
	logic [3:0]  irq_control_r;
	logic [3:0]  irq_masks_r;
	logic [1:0]  port_config_r;
	logic [3:0]  buzzer_control_r;
	logic [3:0]  high_pending_r;
	logic [7:0]  load_r;
	logic [7:0]  count_r;
	logic [3:0]  high_snap_r;
	logic        run_r;
	logic        auto_active_r;
	logic        timer_req_r;
	logic        presc_req_r;
	logic        porta_req_r;
	logic        portc_req_r;
	logic        sleep_r;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic        cpu_irq_r;

	logic        setup_ph;
	logic        acc;
	logic        wr_acc;
	logic        rd_acc;
	logic [7:0]  addr8;
	logic        mapped;
	logic [7:0]  load_nxt;
	logic        low_wr;
	logic        main_rd;
	logic        sleep_wr;

	assign addr8    = paddr[7:0];
	assign setup_ph = psel & ~penable;
	assign acc      = psel & penable & pready_r;
	assign wr_acc   = acc & pwrite;
	assign rd_acc   = acc & ~pwrite;
	assign low_wr   = wr_acc && addr8 == timer_irq_pkg::OFS_TIMER_LOW;
	assign main_rd  = rd_acc && addr8 == timer_irq_pkg::OFS_MAIN_REQUEST;
	assign load_nxt = {high_pending_r, pwdata[3:0]};
	assign sleep_wr = wr_acc && addr8 == timer_irq_pkg::OFS_MAIN_REQUEST
		&& pwdata[timer_irq_pkg::SLEEP_BIT] && irq_masks_r[timer_irq_pkg::GUARD_BIT];

	function automatic logic is_mapped(input logic [7:0] a);
		case (a)
			timer_irq_pkg::OFS_TIMER_CONTROL, timer_irq_pkg::OFS_TIMER_LOW,
			timer_irq_pkg::OFS_TIMER_HIGH, timer_irq_pkg::OFS_PIN_SELECT,
			timer_irq_pkg::OFS_MAIN_REQUEST, timer_irq_pkg::OFS_IRQ_CONTROL,
			timer_irq_pkg::OFS_IRQ_MASKS, timer_irq_pkg::OFS_PORT_CONFIG,
			timer_irq_pkg::OFS_BUZZER_CONTROL: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	assign mapped = is_mapped(addr8) && (paddr >> 8) == '0;

	////////////////////////////////////////////////////////////////////////////
	// prescaler: 32768 hz base tick and its binary taps
	logic [11:0]                        tick_cnt_r;
	logic                               base_tick_r;
	logic [timer_irq_pkg::PRESC_W-1:0]  presc_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r  <= '0;
			base_tick_r <= 1'b0;
		end else if (tick_cnt_r == 12'(TICK_CYC - 1)) begin
			tick_cnt_r  <= '0;
			base_tick_r <= 1'b1;
		end else begin
			tick_cnt_r  <= tick_cnt_r + 12'h001;
			base_tick_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_r <= '0;
		end else if (base_tick_r) begin
			presc_r <= presc_r + 1'b1;
		end
	end

	// one-cycle pulse when the tap of the given shift wraps
	function automatic logic tap_hit(input logic [timer_irq_pkg::PRESC_W-1:0] c, input int sh);
		logic [timer_irq_pkg::PRESC_W-1:0] m;
		m = timer_irq_pkg::PRESC_W'((32'h1 << sh) - 1);
		tap_hit = base_tick_r && ((c & m) == m);
	endfunction : tap_hit

	function automatic logic source_pulse(input logic [2:0] s, input logic pin_edge);
		case (s)
			3'h1: source_pulse = tap_hit(presc_r, timer_irq_pkg::SH_2048);
			3'h2: source_pulse = tap_hit(presc_r, timer_irq_pkg::SH_512);
			3'h3: source_pulse = tap_hit(presc_r, timer_irq_pkg::SH_128);
			3'h4: source_pulse = tap_hit(presc_r, timer_irq_pkg::SH_32);
			3'h5: source_pulse = tap_hit(presc_r, timer_irq_pkg::SH_8);
			3'h6: source_pulse = tap_hit(presc_r, timer_irq_pkg::SH_1);
			3'h7: source_pulse = pin_edge;
			default: source_pulse = 1'b0;
		endcase
	endfunction : source_pulse

	////////////////////////////////////////////////////////////////////////////
	// counter pin: synchroniser, debounce tick, edge unit
	logic                              pin_meta_r;
	logic                              pin_sync_r;
	logic [timer_irq_pkg::DEB_W-1:0]   deb_cnt_r;
	logic                              deb_tick_r;
	logic [timer_irq_pkg::DEB_W-1:0]   deb_last;
	pin_edge_if                        pe ();

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
		end else begin
			pin_meta_r <= counter_input_pin;
			pin_sync_r <= pin_meta_r;
		end
	end

	assign deb_last = irq_control_r[timer_irq_pkg::DEBOUNCER_CLOCK_SELECT_BIT]
		? timer_irq_pkg::DEB_W'(DEB_LONG_CYC - 1) : timer_irq_pkg::DEB_W'(DEB_SHORT_CYC - 1); // R22

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deb_cnt_r  <= '0;
			deb_tick_r <= 1'b0;
		end else if (deb_cnt_r >= deb_last) begin
			deb_cnt_r  <= '0;
			deb_tick_r <= 1'b1;
		end else begin
			deb_cnt_r  <= deb_cnt_r + 1'b1;
			deb_tick_r <= 1'b0;
		end
	end

	assign pe.pin_level   = pin_sync_r;
	assign pe.sample_tick = deb_tick_r;
	assign pe.bypass      = pin_select_r[timer_irq_pkg::PIN_SRC_BIT] & port_config_r[timer_irq_pkg::BYPASS_BIT]; // R12
	assign pe.pick_fall   = pin_select_r[timer_irq_pkg::PIN_SRC_BIT] & ~port_config_r[timer_irq_pkg::EDGE_BIT]; // R12

	pin_edge_unit u_pin_edge (
		.pclk    (pclk),
		.presetn (presetn),
		.pe      (pe)
	);

	////////////////////////////////////////////////////////////////////////////
	// down counter
	logic [2:0] src;
	logic       enabled;
	logic       cnt_tick;
	logic       hit_zero;

	assign src      = timer_control_r[2:0];
	assign enabled  = buzzer_control_r[timer_irq_pkg::RUN_BIT] && src != timer_irq_pkg::SRC_OFF; // R4 R23
	assign cnt_tick = run_r && enabled && source_pulse(src, pe.edge_pulse); // R1 R11
	assign hit_zero = cnt_tick && count_r == 8'h01;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_pending_r <= timer_irq_pkg::RESET_NIBBLE;
		end else if (wr_acc && addr8 == timer_irq_pkg::OFS_TIMER_HIGH) begin
			high_pending_r <= pwdata[3:0]; // R6
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_r        <= 8'h00;
			count_r       <= 8'h00;
			run_r         <= 1'b0;
			auto_active_r <= 1'b0;
		end else if (low_wr) begin
			load_r        <= load_nxt; // R6
			count_r       <= load_nxt; // R5
			run_r         <= load_nxt != 8'h00; // R9
			auto_active_r <= timer_control_r[timer_irq_pkg::AUTO_BIT] && load_nxt != 8'h00; // R7
		end else if (cnt_tick) begin
			if (hit_zero && auto_active_r) begin
				count_r <= load_r; // R8
			end else begin
				count_r <= count_r - 8'h01;
				run_r   <= !hit_zero;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_r <= timer_irq_pkg::RESET_NIBBLE; // R3
		end else if (low_wr && load_nxt == 8'h00) begin
			timer_control_r[timer_irq_pkg::AUTO_BIT] <= 1'b0; // R9
		end else if (wr_acc && addr8 == timer_irq_pkg::OFS_TIMER_CONTROL) begin
			timer_control_r <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_select_r     <= timer_irq_pkg::RESET_NIBBLE;
			irq_masks_r      <= timer_irq_pkg::RESET_NIBBLE; // R14
			port_config_r    <= 2'h0;
			buzzer_control_r <= timer_irq_pkg::RESET_NIBBLE; // R4
		end else if (wr_acc) begin
			case (addr8)
				timer_irq_pkg::OFS_PIN_SELECT:     pin_select_r     <= {1'b0, pwdata[2:0]};
				timer_irq_pkg::OFS_IRQ_MASKS:      irq_masks_r      <= pwdata[3:0];
				timer_irq_pkg::OFS_PORT_CONFIG:    port_config_r    <= pwdata[1:0];
				timer_irq_pkg::OFS_BUZZER_CONTROL: buzzer_control_r <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// global enable: sleep entry beats halt beats software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_control_r <= timer_irq_pkg::RESET_NIBBLE; // R18
		end else begin
			if (wr_acc && addr8 == timer_irq_pkg::OFS_IRQ_CONTROL) begin
				irq_control_r <= pwdata[3:0];
			end
			if (sleep_wr) begin
				irq_control_r[timer_irq_pkg::GLOBAL_IRQ_ENABLE_BIT] <= 1'b0; // R18
			end else if (halt_exec && !swb_auto_start) begin
				irq_control_r[timer_irq_pkg::GLOBAL_IRQ_ENABLE_BIT] <= 1'b1; // R15
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_r <= 1'b0;
		end else if (sleep_wr) begin
			sleep_r <= 1'b1; // R20
		end else if (wake_event) begin
			sleep_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// request flags: a set in the clearing cycle wins
	logic [1:0] psf;
	logic       presc_event;

	assign psf = irq_masks_r[2:1];

	function automatic logic presc_pick(input logic [1:0] sel);
		case (sel)
			2'h1: presc_pick = tap_hit(presc_r, timer_irq_pkg::SH_32);
			2'h2: presc_pick = tap_hit(presc_r, timer_irq_pkg::SH_8);
			default: presc_pick = tap_hit(presc_r, timer_irq_pkg::SH_1);
		endcase
	endfunction : presc_pick

	assign presc_event = presc_pick(psf);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_req_r <= 1'b0;
			presc_req_r <= 1'b0;
		end else begin
			if (hit_zero) begin
				timer_req_r <= 1'b1; // R2 R21
			end else if (main_rd && prdata_r[timer_irq_pkg::REQ_TIMER_BIT]) begin
				timer_req_r <= 1'b0; // R16
			end
			if (presc_event) begin
				presc_req_r <= 1'b1; // R21
			end else if (main_rd && prdata_r[timer_irq_pkg::REQ_PRESC_BIT]) begin
				presc_req_r <= 1'b0; // R16
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			porta_req_r <= 1'b0;
			portc_req_r <= 1'b0;
		end else begin
			if (porta_irq_in) begin
				porta_req_r <= 1'b1;
			end else if (porta_req_read) begin
				porta_req_r <= 1'b0; // R17
			end
			if (portc_irq_in) begin
				portc_req_r <= 1'b1;
			end else if (portc_req_read) begin
				portc_req_r <= 1'b0; // R17
			end
		end
	end

	logic irq_cond;
	assign irq_cond = irq_control_r[timer_irq_pkg::GLOBAL_IRQ_ENABLE_BIT] && !irq_in_service && !sleep_r
		&& ((timer_req_r && irq_masks_r[timer_irq_pkg::TIMER_MASK_BIT_BIT]) || (presc_req_r && psf != 2'h0)
		|| porta_req_r || portc_req_r); // R13 R19

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_irq_r <= 1'b0;
		end else begin
			cpu_irq_r <= irq_cond;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb answer: data captured in setup, one access cycle, no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r    <= '0;
			pready_r    <= 1'b0;
			pslverr_r   <= 1'b0;
			high_snap_r <= timer_irq_pkg::RESET_NIBBLE;
		end else begin
			pready_r  <= setup_ph;
			pslverr_r <= setup_ph && !mapped;
			if (setup_ph && !pwrite) begin
				prdata_r <= '0;
				case (addr8)
					timer_irq_pkg::OFS_TIMER_CONTROL:  prdata_r[3:0] <= timer_control_r;
					timer_irq_pkg::OFS_TIMER_LOW: begin
						prdata_r[3:0] <= count_r[3:0]; // R10
						high_snap_r   <= count_r[7:4]; // R10
					end
					timer_irq_pkg::OFS_TIMER_HIGH:     prdata_r[3:0] <= high_snap_r; // R10
					timer_irq_pkg::OFS_PIN_SELECT:     prdata_r[3:0] <= pin_select_r;
					timer_irq_pkg::OFS_MAIN_REQUEST:   prdata_r[3:0] <= {presc_req_r, timer_req_r, portc_req_r, porta_req_r};
					timer_irq_pkg::OFS_IRQ_CONTROL:    prdata_r[3:0] <= irq_control_r;
					timer_irq_pkg::OFS_IRQ_MASKS:      prdata_r[3:0] <= irq_masks_r;
					timer_irq_pkg::OFS_PORT_CONFIG:    prdata_r[1:0] <= port_config_r;
					timer_irq_pkg::OFS_BUZZER_CONTROL: prdata_r[3:0] <= buzzer_control_r;
					default: ;
				endcase
			end
		end
	end

	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign cpu_irq    = cpu_irq_r;
	assign sleep_mode = sleep_r;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_zero_flag: assert property (hit_zero |=> timer_req_r) // R2
		else $error("zero reach did not set timer flag");
	chk_load_start: assert property (low_wr && load_nxt != 8'h00 |=> run_r && count_r == $past(load_nxt)) // R5
		else $error("low write did not start count");
	chk_zero_stop: assert property (low_wr && load_nxt == 8'h00 |=> !run_r && !timer_control_r[3]) // R9
		else $error("zero load did not stop timer");
	chk_auto_reload: assert property (hit_zero && auto_active_r && !low_wr |=> count_r == load_r && run_r) // R8
		else $error("auto reload missed");
	chk_auto_wait: assert property (!low_wr |=> $stable(auto_active_r) || !auto_active_r) // R7
		else $error("auto reload armed without low write");
	chk_idle_hold: assert property (!enabled && !low_wr |=> $stable(count_r)) // R23
		else $error("counter moved while idle");
	chk_irq_gate: assert property (!irq_control_r[0] |=> !cpu_irq) // R13
		else $error("interrupt without global enable");
	chk_main_clear: assert property (main_rd && prdata_r[2] && !hit_zero |=> !timer_req_r) // R16
		else $error("timer flag not cleared by read");
	chk_port_keep: assert property (main_rd && porta_req_r && !porta_req_read |=> porta_req_r) // R17
		else $error("port flag lost on main read");
	chk_halt_enable: assert property (halt_exec && !swb_auto_start && !sleep_wr |=> irq_control_r[0]) // R15
		else $error("halt did not enable interrupts");
	chk_sleep_entry: assert property (sleep_wr |=> sleep_mode && !irq_control_r[0]) // R20 R18
		else $error("sleep entry wrong");
	chk_apb_answer: assert property (setup_ph |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

	cov_reload: cover property (hit_zero && auto_active_r);
	cov_pin_count: cover property (cnt_tick && src == timer_irq_pkg::SRC_PIN);
	cov_irq: cover property ($rose(cpu_irq));
	cov_sleep: cover property (sleep_wr);
endmodule : countdown_timer_irq
`default_nettype wire

// ---- cpu_model.sv ----
// behavioural cpu core model: halt execution and service routine status
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic cpu_irq,
	input  wire logic halt_req,
	input  wire logic auto_req,
	output logic      halt_exec,
	output logic      swb_auto_start,
	output logic      irq_in_service
);
	logic [3:0] svc_r;
	// an interrupt taken keeps the core in its service routine for eight cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			svc_r <= 4'h0;
		else if (svc_r != 4'h0)
			svc_r <= svc_r - 4'h1;
		else if (cpu_irq)
			svc_r <= 4'h8;
	end
	assign irq_in_service = (svc_r != 4'h0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_exec      <= 1'b0;
			swb_auto_start <= 1'b0;
		end else begin
			halt_exec      <= halt_req;
			swb_auto_start <= auto_req;
		end
	end
endmodule : cpu_model
`default_nettype wire

// ---- countdown_timer_with_irq_gather_tb.sv ----
// self-checking bench for the timer and interrupt gathering block
`timescale 1ns/1ns
`default_nettype none
module countdown_timer_with_irq_gather_tb;
	localparam logic [7:0] CT = timer_irq_pkg::OFS_TIMER_CONTROL;
	localparam logic [7:0] LO = timer_irq_pkg::OFS_TIMER_LOW;
	localparam logic [7:0] HI = timer_irq_pkg::OFS_TIMER_HIGH;
	localparam logic [7:0] MN = timer_irq_pkg::OFS_MAIN_REQUEST;
	localparam logic [7:0] IC = timer_irq_pkg::OFS_IRQ_CONTROL;
	localparam logic [7:0] MK = timer_irq_pkg::OFS_IRQ_MASKS;
	localparam logic [7:0] BZ = timer_irq_pkg::OFS_BUZZER_CONTROL;
	typedef struct packed {logic w; logic [7:0] a; logic [3:0] d; logic [3:0] e;} row_type;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic        pready, pslverr, last_err, cpu_irq, sleep_mode, halt_exec, swb_auto_start, irq_in_service;
	logic        pin = 0, pa_in = 0, pa_rd = 0, pc_in = 0, pc_rd = 0, wake = 0, halt_req = 0, auto_req = 0;
	int          errors = 0, comparisons = 0;
	row_type     rows [15] = '{
		'{0, CT, 0, 0}, '{0, LO, 0, 0}, '{0, HI, 0, 0}, '{0, MK, 0, 0}, '{0, IC, 0, 0}, '{0, BZ, 0, 0},
		'{1, LO, 5, 0}, '{0, LO, 0, 5}, '{0, HI, 0, 0}, '{1, HI, 3, 0}, '{0, LO, 0, 5}, '{0, HI, 0, 0},
		'{1, LO, 1, 0}, '{0, LO, 0, 1}, '{0, HI, 0, 3}};
	always #5 pclk = ~pclk;
	countdown_timer_irq #(.DEB_SHORT_CYC(20), .DEB_LONG_CYC(40), .TICK_CYC(4), .AW(8)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.counter_input_pin(pin), .porta_irq_in(pa_in), .portc_irq_in(pc_in), .porta_req_read(pa_rd),
		.portc_req_read(pc_rd), .halt_exec(halt_exec), .swb_auto_start(swb_auto_start),
		.irq_in_service(irq_in_service), .wake_event(wake), .cpu_irq(cpu_irq), .sleep_mode(sleep_mode));
	cpu_model cpu (.pclk(pclk), .presetn(presetn), .cpu_irq(cpu_irq), .halt_req(halt_req),
		.auto_req(auto_req), .halt_exec(halt_exec), .swb_auto_start(swb_auto_start),
		.irq_in_service(irq_in_service));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic bw(input logic [7:0] a, input logic [3:0] d);
		logic [31:0] q;
		apb(1, a, {28'h0, d}, q);
	endtask : bw
	task automatic halt(input logic a);
		@(posedge pclk);
		auto_req <= a;
		halt_req <= 1;
		@(posedge pclk);
		halt_req <= 0;
		repeat (3) @(posedge pclk);
	endtask : halt
	task automatic wait_irq;
		int n;
		n = 0;
		while (cpu_irq !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_irq
	// each level is held long enough for the debouncer to accept it
	task automatic pulse_pin(input int k);
		repeat (k) begin
			@(posedge pclk) pin <= 1;
			repeat (80) @(posedge pclk);
			pin <= 0;
			repeat (80) @(posedge pclk);
		end
	endtask : pulse_pin
	task automatic wrap_up;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		errors++;
		wrap_up;
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(negedge pclk);
		chk("sleep_mode", 0, sleep_mode);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, {28'h0, rows[i].d}, r);
			if (!rows[i].w) chk("table read", {28'h0, rows[i].e}, r);
		end
		$display("test table done");
		bw(HI, 0);
		bw(CT, 9);
		bw(LO, 2);
		bw(IC, 1);
		bw(BZ, 8);
		repeat (200) @(posedge pclk);
		chk("cpu_irq masked", 0, cpu_irq);
		apb(0, MN, 0, r);
		chk("timer flag unmasked", 4, r);
		bw(MK, 1);
		wait_irq();
		chk("cpu_irq", 1, cpu_irq);
		apb(0, MN, 0, r);
		chk("timer flag", 4, r);
		apb(0, MN, 0, r);
		chk("flag cleared", 0, r);
		$display("test timer done");
		bw(HI, 0);
		bw(LO, 0);
		apb(0, CT, 0, r);
		chk("auto cleared", 1, r);
		repeat (300) @(posedge pclk);
		apb(0, MN, 0, r);
		chk("stopped flag", 0, r);
		$display("test zero load done");
		bw(IC, 0);
		halt(1);
		apb(0, IC, 0, r);
		chk("halt swb", 0, r);
		halt(0);
		apb(0, IC, 0, r);
		chk("halt global_irq_enable", 1, r);
		$display("test halt done");
		bw(MN, 4);
		chk("sleep guarded", 0, sleep_mode);
		bw(MK, 8);
		bw(MN, 4);
		repeat (2) @(posedge pclk);
		chk("sleep", 1, sleep_mode);
		apb(0, IC, 0, r);
		chk("sleep global_irq_enable", 0, r);
		@(posedge pclk) wake <= 1;
		@(posedge pclk) wake <= 0;
		$display("test sleep done");
		@(posedge pclk) begin
			pa_in <= 1;
			pc_in <= 1;
		end
		@(posedge pclk) begin
			pa_in <= 0;
			pc_in <= 0;
		end
		apb(0, MN, 0, r);
		apb(0, MN, 0, r);
		chk("port flags kept", 3, r);
		@(posedge pclk) pa_rd <= 1;
		@(posedge pclk) pa_rd <= 0;
		apb(0, MN, 0, r);
		chk("porta flag cleared", 2, r);
		@(posedge pclk) pc_rd <= 1;
		@(posedge pclk) pc_rd <= 0;
		apb(0, MN, 0, r);
		chk("port flag cleared", 0, r);
		$display("test port flags done");
		bw(CT, 7);
		bw(LO, 3);
		pulse_pin(2);
		apb(0, LO, 0, r);
		chk("pin count", 1, r);
		pulse_pin(1);
		apb(0, MN, 0, r);
		chk("pin zero flag", 4, r);
		$display("test pin done");
		apb(0, 8'h24, 0, r);
		chk("unmapped err", 1, last_err);
		chk("unmapped data", 0, r);
		$display("test unmapped done");
		wrap_up;
	end
endmodule : countdown_timer_with_irq_gather_tb
`default_nettype wire
